// ===== rtl/dmt_pkg.sv
package dmt_pkg;
   // register offsets on the byte port
   localparam logic [3:0] OFS_CTRL_A = 4'h0;
   localparam logic [3:0] OFS_CTRL_B = 4'h1;
   localparam logic [3:0] OFS_ADDR_CTRL = 4'h2;
   localparam logic [3:0] OFS_TRIG = 4'h3;
   localparam logic [3:0] OFS_CNT_LO = 4'h4;
   localparam logic [3:0] OFS_CNT_HI = 4'h5;
   localparam logic [3:0] OFS_REP = 4'h6;
   localparam logic [3:0] OFS_SRC0 = 4'h8;
   localparam logic [3:0] OFS_SRC1 = 4'h9;
   localparam logic [3:0] OFS_SRC2 = 4'ha;
   localparam logic [3:0] OFS_DST0 = 4'hc;
   localparam logic [3:0] OFS_DST1 = 4'hd;
   localparam logic [3:0] OFS_DST2 = 4'he;
   // field positions
   localparam int BIT_ENABLE = 7;
   localparam int BIT_REPEAT = 5;
   localparam int BIT_TRFREQ = 4;
   localparam int BIT_BUSY = 7;
   localparam int BIT_TRANSACTION_COMPLETE_FLAG = 4;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_CNT = 16'h0000;
   localparam logic [23:0] RST_ADDR = 24'h000000;
   // trigger codes
   localparam logic [7:0] TRIG_OFF = 8'h00;
   localparam logic [7:0] TRIG_SYS = 8'h01;
   localparam logic [7:0] TRIG_ADC_A = 8'h10;
   localparam logic [7:0] TRIG_DAC_A = 8'h15;
   localparam logic [7:0] TRIG_ADC_B = 8'h20;
   localparam logic [7:0] TRIG_DAC_B = 8'h25;
   localparam logic [7:0] TRIG_PORT0 = 8'h40;
   localparam logic [7:0] PORT_STRIDE = 8'h20;
   localparam logic [7:0] OFF_TC1 = 8'h06;
   localparam logic [7:0] OFF_SPI = 8'h0a;
   localparam logic [7:0] OFF_USART0 = 8'h0b;
   localparam logic [7:0] OFF_USART1 = 8'h0e;
   localparam logic [7:0] OFF_ADC_OR = 8'h04;
   localparam logic [7:0] NUM_SYS = 8'h03;
   localparam logic [7:0] NUM_ADC = 8'h04;
   localparam logic [7:0] NUM_DAC = 8'h02;
   localparam logic [7:0] NUM_TC0 = 8'h06;
   localparam logic [7:0] NUM_TC1 = 8'h04;
   localparam logic [7:0] NUM_USART = 8'h02;

   typedef enum logic [1:0] {
      DMT_DIR_FIXED = 2'b00,
      DMT_DIR_INC = 2'b01,
      DMT_DIR_DEC = 2'b10,
      DMT_DIR_RSVD = 2'b11
   } dmt_dir_t;

   typedef enum logic [1:0] {
      DMT_RLD_NONE = 2'b00,
      DMT_RLD_BLOCK = 2'b01,
      DMT_RLD_BURST = 2'b10,
      DMT_RLD_TRANS = 2'b11
   } dmt_reload_t;

   typedef enum logic [1:0] {
      DMT_IDLE = 2'b00,
      DMT_RD = 2'b01,
      DMT_CAP = 2'b10,
      DMT_WR = 2'b11
   } dmt_state_t;
endpackage : dmt_pkg

// ===== rtl/dmt_channel.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
//Operation
// - trigger code zero ignores hardware requests; only software request starts
// - trigger code equals peripheral base code plus source offset
// - bases: system 0x01, input converters 0x10/0x20, output converters 0x15/0x25
// - port groups based at 0x40, 0x60, 0x80, 0xA0; first timer at base
// - second timer +6, spi +0xA, serial ports +0xB and +0xE
// - system offsets 0..2 select event routing channels 0..2
// - converter offsets 0..3 channels, 4 ORs inputs; outputs only 0 and 1
// - timer offsets 0..5: overflow, error, compare A, B, C, D
// - compare C and D exist only on each group's first timer
// - serial offset 0 receive complete, offset 1 transmit empty
// - codes naming absent peripherals select nothing
// - 16-bit block byte count held as high and low byte registers
// - block byte count decrements after every byte read
// - on reaching zero the count reloads the last written value
// - 16-bit count accessed atomically through a temporary byte
// - repeat counter decrements after each completed block
// - repeat mode: channel disables after counter zero and last block
// - repeat counter zero with repeat mode repeats blocks without limit
// - 24-bit source address in three bytes, byte 2 most significant
// - source address steps up, down or holds per source direction
// - 24-bit destination address in three bytes, byte 2 most significant
// - destination address steps up, down or holds per destination direction
// - 24-bit addresses accessed atomically through temporary bytes
// - direction codes: 00 fixed, 01 increment, 10 decrement, 11 reserved
// - repeat enable cleared by hardware at start of last block
// - transaction flag after every block when unlimited, else after final
module dmt_channel #(
   parameter logic [3:0] PORT_PRESENT = 4'hf,
   parameter logic [1:0] ADC_PRESENT = 2'h3,
   parameter logic [1:0] DAC_PRESENT = 2'h3
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] rd_data,
   input wire logic [2:0] sys_event_req,
   input wire logic [7:0] adc_req,
   input wire logic [3:0] dac_req,
   input wire logic [23:0] tc0_req,
   input wire logic [15:0] tc1_req,
   input wire logic [3:0] spi_req,
   input wire logic [7:0] usart0_req,
   input wire logic [7:0] usart1_req,
   input wire logic [7:0] mem_rdata,
   output logic mem_rd,
   output logic [23:0] mem_rd_addr,
   output logic mem_wr,
   output logic [23:0] mem_wr_addr,
   output logic [7:0] mem_wdata,
   output logic chan_busy,
   output logic transaction_complete_flag
);
   dmt_pkg::dmt_state_t state;
   dmt_pkg::dmt_state_t next_state;
   logic enable;
   logic repeat_en;
   logic trfreq;
   logic [7:0] addr_ctrl;
   logic [7:0] trigger_select;
   logic [15:0] temp;
   logic [15:0] count_written;
   logic [15:0] block_byte_count;
   logic [7:0] block_repeat_counter;
   logic [23:0] source_address;
   logic [23:0] src_init;
   logic [23:0] dest_address;
   logic [23:0] dst_init;
   logic block_last;
   logic [1:0] conv_hit;
   logic [3:0] port_hit;
   logic sys_hit;
   logic hw_req;
   logic start;
   logic rd_step;
   logic wr_step;
   logic block_done;
   logic unlimited;
   logic count_end;
   logic trn_end;
   logic [7:0] sys_off;
   logic [1:0] src_reload;
   logic [1:0] src_dir;
   logic [1:0] dst_reload;
   logic [1:0] dst_dir;

   assign src_reload = addr_ctrl[7:6];
   assign src_dir = addr_ctrl[5:4];
   assign dst_reload = addr_ctrl[3:2];
   assign dst_dir = addr_ctrl[1:0];

   function automatic logic [23:0] dmt_step(input logic [23:0] a, input logic [1:0] dir);
      case (dir)
         dmt_pkg::DMT_DIR_INC: dmt_step = a + 24'h000001;
         dmt_pkg::DMT_DIR_DEC: dmt_step = a - 24'h000001;
         default: dmt_step = a;
      endcase
   endfunction : dmt_step

   // trigger decode: code minus group base gives the source offset
   always_comb
   begin
      sys_off = trigger_select - dmt_pkg::TRIG_SYS;
      sys_hit = (sys_off < dmt_pkg::NUM_SYS) && sys_event_req[sys_off[1:0]];
   end

   for (genvar g = 0; g < 2; g++)
   begin : g_conv
      localparam logic [7:0] ADC_BASE = (g == 0) ? dmt_pkg::TRIG_ADC_A : dmt_pkg::TRIG_ADC_B;
      localparam logic [7:0] DAC_BASE = (g == 0) ? dmt_pkg::TRIG_DAC_A : dmt_pkg::TRIG_DAC_B;
      logic [7:0] adc_off;
      logic [7:0] dac_off;
      logic adc_hit;
      logic dac_hit;
      always_comb
      begin
         adc_off = trigger_select - ADC_BASE;
         dac_off = trigger_select - DAC_BASE;
         adc_hit = 1'b0;
         if (adc_off < dmt_pkg::NUM_ADC)
            adc_hit = adc_req[g * 4 + int'(adc_off[1:0])];
         else if (adc_off == dmt_pkg::OFF_ADC_OR)
            adc_hit = |adc_req[g * 4 +: 4];
         dac_hit = (dac_off < dmt_pkg::NUM_DAC) && dac_req[g * 2 + int'(dac_off[0])];
         conv_hit[g] = (ADC_PRESENT[g] && adc_hit) || (DAC_PRESENT[g] && dac_hit);
      end
   end

   for (genvar g = 0; g < 4; g++)
   begin : g_port
      localparam logic [7:0] GBASE = 8'(dmt_pkg::TRIG_PORT0 + g * dmt_pkg::PORT_STRIDE);
      logic [7:0] off;
      logic [7:0] off_tc1;
      logic [7:0] off_u0;
      logic [7:0] off_u1;
      logic hit;
      always_comb
      begin
         off = trigger_select - GBASE;
         off_tc1 = off - dmt_pkg::OFF_TC1;
         off_u0 = off - dmt_pkg::OFF_USART0;
         off_u1 = off - dmt_pkg::OFF_USART1;
         hit = 1'b0;
         if (off < dmt_pkg::NUM_TC0)
            hit = tc0_req[g * 6 + int'(off[2:0])];
         else if (off_tc1 < dmt_pkg::NUM_TC1)
            hit = tc1_req[g * 4 + int'(off_tc1[1:0])];
         else if (off == dmt_pkg::OFF_SPI)
            hit = spi_req[g];
         else if (off_u0 < dmt_pkg::NUM_USART)
            hit = usart0_req[g * 2 + int'(off_u0[0])];
         else if (off_u1 < dmt_pkg::NUM_USART)
            hit = usart1_req[g * 2 + int'(off_u1[0])];
         port_hit[g] = PORT_PRESENT[g] && hit;
      end
   end

   assign hw_req = sys_hit || (|conv_hit) || (|port_hit);
   // hardware requests only count with a nonzero code
   assign start = enable && (state == dmt_pkg::DMT_IDLE)
      && (trfreq || ((trigger_select != dmt_pkg::TRIG_OFF) && hw_req));
   assign rd_step = (state == dmt_pkg::DMT_RD);
   assign wr_step = (state == dmt_pkg::DMT_WR);
   assign block_done = wr_step && block_last;
   localparam logic [7:0] RST_REP = dmt_pkg::RST_BYTE;
   assign unlimited = repeat_en && (block_repeat_counter == RST_REP);
   assign count_end = rd_step && (block_byte_count == 16'h0001);
   assign trn_end = !repeat_en || unlimited;

   always_comb
   begin
      case (state)
         dmt_pkg::DMT_IDLE: next_state = start ? dmt_pkg::DMT_RD : dmt_pkg::DMT_IDLE;
         dmt_pkg::DMT_RD: next_state = dmt_pkg::DMT_CAP;
         dmt_pkg::DMT_CAP: next_state = dmt_pkg::DMT_WR;
         dmt_pkg::DMT_WR: next_state = block_last ? dmt_pkg::DMT_IDLE : dmt_pkg::DMT_RD;
         default: next_state = dmt_pkg::DMT_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         state <= dmt_pkg::DMT_IDLE;
      else
         state <= next_state;
   end

   // memory side: read strobe in RD, data arrives in CAP, write strobe in WR
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         mem_rd_addr <= dmt_pkg::RST_ADDR;
         mem_wr_addr <= dmt_pkg::RST_ADDR;
         mem_wdata <= dmt_pkg::RST_BYTE;
         chan_busy <= 1'b0;
      end
      else
      begin
         mem_rd <= (next_state == dmt_pkg::DMT_RD);
         mem_wr <= (next_state == dmt_pkg::DMT_WR);
         chan_busy <= (next_state != dmt_pkg::DMT_IDLE);
         if (next_state == dmt_pkg::DMT_RD)
            mem_rd_addr <= source_address;
         if (next_state == dmt_pkg::DMT_WR)
            mem_wr_addr <= dest_address;
         if (state == dmt_pkg::DMT_CAP)
            mem_wdata <= mem_rdata;
      end
   end

   // control bits; a software write beats a same-cycle hardware clear
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         enable <= 1'b0;
         repeat_en <= 1'b0;
         trfreq <= 1'b0;
      end
      else if (reg_wr && reg_addr == dmt_pkg::OFS_CTRL_A)
      begin
         enable <= reg_wdata[dmt_pkg::BIT_ENABLE];
         repeat_en <= reg_wdata[dmt_pkg::BIT_REPEAT];
         trfreq <= reg_wdata[dmt_pkg::BIT_TRFREQ];
      end
      else
      begin
         if (start)
            trfreq <= 1'b0;
         if (start && repeat_en && block_repeat_counter == 8'h01)
            repeat_en <= 1'b0;
         if (block_done && !repeat_en)
            enable <= 1'b0;
      end
   end

   // set wins over the write-one clear
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         transaction_complete_flag <= 1'b0;
      else if (block_done && trn_end)
         transaction_complete_flag <= 1'b1;
      else if (reg_wr && reg_addr == dmt_pkg::OFS_CTRL_B && reg_wdata[dmt_pkg::BIT_TRANSACTION_COMPLETE_FLAG])
         transaction_complete_flag <= 1'b0;
   end

   // address control is frozen while a block runs
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         addr_ctrl <= dmt_pkg::RST_BYTE;
         trigger_select <= dmt_pkg::RST_BYTE;
      end
      else if (reg_wr)
      begin
         if (reg_addr == dmt_pkg::OFS_ADDR_CTRL && state == dmt_pkg::DMT_IDLE)
            addr_ctrl <= reg_wdata;
         if (reg_addr == dmt_pkg::OFS_TRIG)
            trigger_select <= reg_wdata;
      end
   end

   // temporary bytes: low-byte writes park, top-byte write commits; low-byte read latches
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         temp <= dmt_pkg::RST_CNT;
      else if (reg_wr)
      begin
         if (reg_addr == dmt_pkg::OFS_CNT_LO || reg_addr == dmt_pkg::OFS_SRC0
             || reg_addr == dmt_pkg::OFS_DST0)
            temp[7:0] <= reg_wdata;
         if (reg_addr == dmt_pkg::OFS_SRC1 || reg_addr == dmt_pkg::OFS_DST1)
            temp[15:8] <= reg_wdata;
      end
      else if (reg_rd)
      begin
         if (reg_addr == dmt_pkg::OFS_CNT_LO)
            temp[7:0] <= block_byte_count[15:8];
         if (reg_addr == dmt_pkg::OFS_SRC0)
            temp <= source_address[23:8];
         if (reg_addr == dmt_pkg::OFS_DST0)
            temp <= dest_address[23:8];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         count_written <= dmt_pkg::RST_CNT;
         block_byte_count <= dmt_pkg::RST_CNT;
         block_last <= 1'b0;
      end
      else
      begin
         if (reg_wr && reg_addr == dmt_pkg::OFS_CNT_HI)
            count_written <= {reg_wdata, temp[7:0]};
         if (reg_wr && reg_addr == dmt_pkg::OFS_CNT_HI && state == dmt_pkg::DMT_IDLE)
            block_byte_count <= {reg_wdata, temp[7:0]};
         else if (count_end)
            block_byte_count <= count_written;
         else if (rd_step)
            block_byte_count <= block_byte_count - 16'h0001;
         if (rd_step)
            block_last <= count_end;
      end
   end

   // a write made in the same cycle as a block end loses the decrement
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         block_repeat_counter <= dmt_pkg::RST_BYTE;
      else if (reg_wr && reg_addr == dmt_pkg::OFS_REP)
         block_repeat_counter <= reg_wdata;
      else if (block_done && block_repeat_counter != RST_REP)
         block_repeat_counter <= block_repeat_counter - 8'h01;
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         source_address <= dmt_pkg::RST_ADDR;
         src_init <= dmt_pkg::RST_ADDR;
      end
      else if (reg_wr && reg_addr == dmt_pkg::OFS_SRC2)
      begin
         source_address <= {reg_wdata, temp};
         src_init <= {reg_wdata, temp};
      end
      else if (rd_step)
      begin
         if (src_reload == dmt_pkg::DMT_RLD_BURST
             || (src_reload == dmt_pkg::DMT_RLD_BLOCK && count_end)
             || (src_reload == dmt_pkg::DMT_RLD_TRANS && count_end && trn_end))
            source_address <= src_init;
         else
            source_address <= dmt_step(source_address, src_dir);
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dest_address <= dmt_pkg::RST_ADDR;
         dst_init <= dmt_pkg::RST_ADDR;
      end
      else if (reg_wr && reg_addr == dmt_pkg::OFS_DST2)
      begin
         dest_address <= {reg_wdata, temp};
         dst_init <= {reg_wdata, temp};
      end
      else if (wr_step)
      begin
         if (dst_reload == dmt_pkg::DMT_RLD_BURST
             || (dst_reload == dmt_pkg::DMT_RLD_BLOCK && block_last)
             || (dst_reload == dmt_pkg::DMT_RLD_TRANS && block_last && trn_end))
            dest_address <= dst_init;
         else
            dest_address <= dmt_step(dest_address, dst_dir);
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         rd_data <= dmt_pkg::RST_BYTE;
      else if (!reg_rd)
         rd_data <= dmt_pkg::RST_BYTE;
      else
         case (reg_addr)
            dmt_pkg::OFS_CTRL_A: rd_data <= {enable, 1'b0, repeat_en, trfreq, 4'h0};
            dmt_pkg::OFS_CTRL_B: rd_data <= {chan_busy, 2'b00, transaction_complete_flag, 4'h0};
            dmt_pkg::OFS_ADDR_CTRL: rd_data <= addr_ctrl;
            dmt_pkg::OFS_TRIG: rd_data <= trigger_select;
            dmt_pkg::OFS_CNT_LO: rd_data <= block_byte_count[7:0];
            dmt_pkg::OFS_CNT_HI: rd_data <= temp[7:0];
            dmt_pkg::OFS_REP: rd_data <= block_repeat_counter;
            dmt_pkg::OFS_SRC0: rd_data <= source_address[7:0];
            dmt_pkg::OFS_SRC1: rd_data <= temp[7:0];
            dmt_pkg::OFS_SRC2: rd_data <= temp[15:8];
            dmt_pkg::OFS_DST0: rd_data <= dest_address[7:0];
            dmt_pkg::OFS_DST1: rd_data <= temp[7:0];
            dmt_pkg::OFS_DST2: rd_data <= temp[15:8];
            default: rd_data <= dmt_pkg::RST_BYTE;
         endcase
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   a_off_sw_only: assert property (start |-> trfreq || trigger_select != 8'h00)
      else $error("start without software request while trigger off");
   a_sys_decode: assert property (trigger_select == 8'h03 && sys_event_req[2] |-> hw_req)
      else $error("system channel 2 request not decoded");
   a_tc1_no_ccc: assert property (trigger_select == 8'h4a && !spi_req[0] |-> !port_hit[0])
      else $error("second timer compare C decoded");
   a_count_dec: assert property (rd_step && block_byte_count != 16'h0001
      |=> block_byte_count == $past(block_byte_count) - 16'h0001)
      else $error("block count did not decrement");
   a_count_reload: assert property (count_end && !reg_wr |=> block_byte_count == count_written)
      else $error("block count not reloaded");
   a_cnt_atomic: assert property (reg_wr && reg_addr == 4'h4 |=> $stable(count_written))
      else $error("low byte write changed count");
   a_rep_dec: assert property (block_done && block_repeat_counter != 8'h00 && !reg_wr
      |=> block_repeat_counter == $past(block_repeat_counter) - 8'h01)
      else $error("repeat counter did not decrement");
   a_last_disable: assert property (block_done && !repeat_en && !reg_wr
      |=> !enable ##1 !chan_busy)
      else $error("channel not disabled after final block");
   a_repeat_clear: assert property (start && repeat_en && block_repeat_counter == 8'h01
      && !reg_wr |=> !repeat_en)
      else $error("repeat not cleared at last block");
   a_unlimited_flag: assert property (block_done && unlimited && !reg_wr
      |=> transaction_complete_flag && enable)
      else $error("unlimited block did not flag");
   a_src_inc: assert property (rd_step && src_dir == 2'b01 && src_reload == 2'b00
      && !reg_wr |=> source_address == $past(source_address) + 24'h000001)
      else $error("source address did not increment");
   a_dst_dec: assert property (wr_step && dst_dir == 2'b10 && dst_reload == 2'b00
      && !reg_wr |=> dest_address == $past(dest_address) - 24'h000001)
      else $error("destination address did not decrement");
   a_byte_seq: assert property (start |=> mem_rd ##2 mem_wr)
      else $error("byte read and write out of sequence");

   c_hw_start: cover property (start && !trfreq);
   c_unlimited: cover property (block_done && unlimited);
   c_final_block: cover property (block_done && !repeat_en);
   c_src_reload: cover property (rd_step && src_reload == 2'b01 && count_end);
endmodule : dmt_channel

// ===== dv/dmt_mem_model.sv
`timescale 1ns/100ps
module dmt_mem_model (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic mem_rd,
   input wire logic [23:0] mem_rd_addr,
   output logic [7:0] mem_rdata
);
   logic valid;
   logic [7:0] held;
   // source byte is a pattern of its address
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         valid <= 1'b0;
         held <= 8'h00;
      end
      else
      begin
         valid <= mem_rd;
         if (mem_rd)
            held <= mem_rd_addr[7:0] ^ 8'h5a;
      end
   end
   // off-cycle the bus shows the inverse, so a late sample is caught
   assign mem_rdata = valid ? held : ~held;
endmodule : dmt_mem_model

// ===== dv/dma_channel_trigger_and_counters_bench.sv
`timescale 1ns/100ps
module dma_channel_trigger_and_counters_bench;
   logic core_clk, rst_b, reg_wr, reg_rd, mem_rd, mem_wr, chan_busy, trn_flag;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, rd_data, mem_rdata, mem_wdata;
   logic [23:0] mem_rd_addr, mem_wr_addr;
   logic [74:0] req;
   logic [31:0] wlog[$];
   int n_fail, samples_checked;
   // hit flag [16], request bit [15:8] (ff = all), code [7:0]
   int tab[19] = '{'h10001, 'h10203, 'h10310, 'h10414, 'h10a23, 'h10c16, 'h10d25,
      'h10f40, 'h11a65, 'h12f86, 'h136a9, 'h1398a, 'h141ab, 'h1444f,
      'h0ff00, 'h0ff17, 'h0ff4d, 'h0ffc0, 'h00410};
   dmt_channel i_dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .rd_data(rd_data),
      .sys_event_req(req[2:0]), .adc_req(req[10:3]), .dac_req(req[14:11]),
      .tc0_req(req[38:15]), .tc1_req(req[54:39]), .spi_req(req[58:55]),
      .usart0_req(req[66:59]), .usart1_req(req[74:67]), .mem_rdata(mem_rdata),
      .mem_rd(mem_rd), .mem_rd_addr(mem_rd_addr), .mem_wr(mem_wr),
      .mem_wr_addr(mem_wr_addr), .mem_wdata(mem_wdata), .chan_busy(chan_busy),
      .transaction_complete_flag(trn_flag));
   dmt_mem_model i_mem (.core_clk(core_clk), .rst_b(rst_b), .mem_rd(mem_rd),
      .mem_rd_addr(mem_rd_addr), .mem_rdata(mem_rdata));
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
      if (mem_wr === 1'b1)
         wlog.push_back({mem_wdata, mem_wr_addr});
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(32'(rd_data), 32'(exp));
   endtask : rd
   // bounded wait for the block to finish
   task wait_idle;
      repeat (3) @(posedge core_clk);
      #1;
      for (int i = 0; i < 40 && chan_busy !== 1'b0; i++)
      begin
         @(posedge core_clk);
         #1;
      end
      chk(32'(chan_busy), 32'h0);
   endtask : wait_idle
   task trig(input int e);
      logic seen;
      seen = 1'b0;
      wr(4'h3, e[7:0]);
      wr(4'h0, 8'h80);
      @(posedge core_clk);
      req <= (e[15:8] == 8'hff) ? '1 : 75'(1) << e[15:8];
      repeat (8)
      begin
         @(posedge core_clk);
         #1;
         if (mem_rd === 1'b1)
            seen = 1'b1;
      end
      @(posedge core_clk);
      req <= '0;
      chk(32'(seen), 32'(e[16]));
      wr(4'h0, 8'h00);
      wait_idle;
      wr(4'h1, 8'h10);
   endtask : trig
   task final_report;
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   initial
   begin
      #2_000_000;
      n_fail++;
      final_report;
   end
   initial
   begin
      {reg_addr, reg_wdata, reg_wr, reg_rd, req} = '0;
      rst_b = 1'b0;
      repeat (8) @(posedge core_clk);
      rst_b <= 1'b1;
      rd(4'h9, 8'h00);
      wr(4'h8, 8'h10);
      wr(4'h9, 8'h00);
      wr(4'ha, 8'h00);
      wr(4'hc, 8'h00);
      wr(4'hd, 8'h01);
      wr(4'he, 8'h02);
      wr(4'h7, 8'hff);
      rd(4'h7, 8'h00);
      rd(4'hc, 8'h00);
      rd(4'hd, 8'h01);
      rd(4'he, 8'h02);
      wr(4'h4, 8'h03);
      wr(4'h5, 8'h00);
      rd(4'h4, 8'h03);
      rd(4'h5, 8'h00);
      $display("test registers done");
      wr(4'h2, 8'h12);
      wr(4'h0, 8'h90);
      wait_idle;
      chk(32'(trn_flag), 32'h1);
      chk(32'(wlog.size()), 32'd3);
      for (int i = 0; i < 3; i++)
         chk(wlog[i], {8'(8'h10 + i) ^ 8'h5a, 24'(24'h020100 - i)});
      rd(4'h1, 8'h10);
      rd(4'h0, 8'h00);
      rd(4'h4, 8'h03);
      rd(4'h5, 8'h00);
      rd(4'h8, 8'h13);
      rd(4'hc, 8'hfd);
      $display("test block done");
      wr(4'h1, 8'h10);
      wr(4'h2, 8'h5e);
      wr(4'h4, 8'h01);
      wr(4'h5, 8'h00);
      wr(4'h6, 8'h02);
      wr(4'h0, 8'hb0);
      wait_idle;
      rd(4'h6, 8'h01);
      chk(32'(trn_flag), 32'h0);
      rd(4'h1, 8'h00);
      rd(4'h0, 8'ha0);
      wr(4'h0, 8'hb0);
      wait_idle;
      rd(4'h6, 8'h00);
      rd(4'h1, 8'h10);
      rd(4'h0, 8'h00);
      wr(4'h1, 8'h10);
      wr(4'h0, 8'hb0);
      wait_idle;
      rd(4'h1, 8'h10);
      rd(4'h0, 8'ha0);
      rd(4'h8, 8'h10);
      rd(4'hc, 8'h00);
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h10);
      $display("test repeat done");
      foreach (tab[i])
         trig(tab[i]);
      $display("test triggers done");
      final_report;
   end
endmodule : dma_channel_trigger_and_counters_bench
